// [mtw_pkg.sv]
// constants shared by the three-counter timer block with watchdog
// assumes one subsystem clock and plain control ports driven by software logic
// Behaviour
// - three 16-bit down counters, reload or stop
// - each counter pulses interrupt on zero
// - counter zero is watchdog or general purpose
// - shared pin pulses low on counter two event
// - count from reload, step per prescale group
// - period is (reload+1) times two^(exponent+1)
// - auto reload restarts count without software
// - counter steps only while run bit set, except counter zero in watchdog mode, which always runs
// - present count always readable
// - watchdog expiry pulses subsys_reset_out and restores watchdog settings
// - status records watchdog caused last reset
// - watchdog reload ignored if value unchanged
// - power-up: watchdog, reload FFFF, exponent seven
// - second key disables, repeated first stays armed
// - watchdog bit re-enables and forces FFFF
package mtw_pkg;
  localparam int CNT_W = 16;
  localparam int PTV_W = 3;
  localparam int PRE_W = 8;
  localparam int KEY_W = 8;
  localparam int NUM_CNT = 3;
  localparam logic [KEY_W-1:0] KEY_FIRST = 8'hF5;
  localparam logic [KEY_W-1:0] KEY_SECOND = 8'hA0;
  localparam logic [CNT_W-1:0] WD_RELOAD_RST = 16'hFFFF;
  localparam logic [PTV_W-1:0] WD_PTV_RST = 3'h7;
  localparam logic [PTV_W-1:0] PTV_MAX = 3'h7;
  localparam logic [PRE_W-1:0] PRE_FULL = 8'hFF;
  localparam int SHARED_CNT = 2;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b01,
    KEY_ARMED = 2'b10
  } mtw_key_type;

  // last prescaler value of a group of 2^(exponent+1) clocks
  function automatic logic [PRE_W-1:0] mtw_group_last(input logic [PTV_W-1:0] prescale_exponent);
    mtw_group_last = PRE_FULL >> (PTV_MAX - prescale_exponent);
  endfunction : mtw_group_last
endpackage : mtw_pkg

// [mtw_counter.sv]
// one down counter with power-of-two prescaler
// assumes control inputs come from logic on the same clock
`timescale 1ns/1ps
module mtw_counter (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic run_bit_in,
  input wire logic auto_reload_flag_in,
  input wire logic [mtw_pkg::PTV_W-1:0] prescale_exponent_in,
  input wire logic [mtw_pkg::CNT_W-1:0] reload_value_in,
  input wire logic load_in,
  output logic [mtw_pkg::CNT_W-1:0] count_out,
  output logic zero_evt_out
);
  import mtw_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [PRE_W-1:0] presc;
    logic run_q;
    logic done;
    logic evt;
  } mtw_cnt_state_type;

  mtw_cnt_state_type s_r;
  mtw_cnt_state_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.evt = 1'b0;
    s_nxt.run_q = run_bit_in;
    if (load_in || (run_bit_in && !s_r.run_q)) begin
      s_nxt.count = reload_value_in;
      s_nxt.presc = '0;
      s_nxt.done = 1'b0;
    end else if (run_bit_in && !s_r.done) begin
      if (s_r.presc == mtw_group_last(prescale_exponent_in)) begin
        s_nxt.presc = '0;
        if (s_r.count == '0) begin
          s_nxt.evt = 1'b1;
          if (auto_reload_flag_in) begin
            s_nxt.count = reload_value_in;
          end else begin
            s_nxt.done = 1'b1;
          end
        end else begin
          s_nxt.count = s_r.count - 16'h0001;
        end
      end else begin
        s_nxt.presc = s_r.presc + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count_out = s_r.count;
  assign zero_evt_out = s_r.evt;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence held_stopped;
    !run_bit_in && !load_in;
  endsequence

  a_run_hold_count: assert property (held_stopped ##1 held_stopped |-> $stable(count_out))
    else $error("count moved while run bit clear");
  a_oneshot_holds: assert property (zero_evt_out && !$past(auto_reload_flag_in) && !load_in && run_bit_in
      |=> count_out == '0 && !zero_evt_out)
    else $error("one-shot counter did not hold at zero");
  a_reload_on_zero: assert property (zero_evt_out && $past(auto_reload_flag_in)
      |-> count_out == $past(reload_value_in))
    else $error("auto reload value not taken");
  a_evt_from_zero: assert property (zero_evt_out |-> $past(count_out) == '0)
    else $error("event without zero count");
endmodule : mtw_counter

// [mtw_timers.sv]
// three counters, counter zero watchdog with key unlock, counter two pin pulse
// assumes control strobes are one-cycle pulses from software logic on clk_sys_in
`timescale 1ns/1ps
module mtw_timers (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [mtw_pkg::NUM_CNT-1:0] run_bit_in,
  input wire logic [mtw_pkg::NUM_CNT-1:0] auto_reload_flag_in,
  input wire logic [mtw_pkg::NUM_CNT-1:0][mtw_pkg::PTV_W-1:0] prescale_exponent_in,
  input wire logic [mtw_pkg::NUM_CNT-1:0][mtw_pkg::CNT_W-1:0] reload_value_in,
  input wire logic [mtw_pkg::NUM_CNT-1:0] reload_write_in,
  input wire logic counter_zero_control_write_in,
  input wire logic [mtw_pkg::KEY_W-1:0] disable_key_field_in,
  input wire logic watchdog_bit_in,
  input wire logic reset_cause_clear_in,
  input wire logic shared_io_timer_sel_in,
  input wire logic gpio_data_in,
  input wire logic gpio_oe_in,
  output logic [mtw_pkg::NUM_CNT-1:0][mtw_pkg::CNT_W-1:0] count_readback_out,
  output logic [mtw_pkg::NUM_CNT-1:0] irq_out,
  output logic subsys_reset_out,
  output logic watchdog_mode_out,
  output logic watchdog_reset_cause_out,
  output logic shared_io_pin_out,
  output logic shared_io_pin_oe_out
);
  import mtw_pkg::*;

  typedef struct packed {
    logic wd_mode;
    mtw_key_type key;
    logic [CNT_W-1:0] wd_reload;
    logic [PTV_W-1:0] wd_ptv;
    logic [CNT_W-1:0] last_load;
    logic wd_load;
    logic cause;
    logic rst_pulse;
    logic pin;
    logic pin_oe;
  } mtw_top_state_type;

  mtw_top_state_type s_r;
  mtw_top_state_type s_nxt;
  logic [NUM_CNT-1:0] eff_run;
  logic [NUM_CNT-1:0] eff_ar;
  logic [NUM_CNT-1:0][PTV_W-1:0] eff_ptv;
  logic [NUM_CNT-1:0][CNT_W-1:0] eff_reload;
  logic [NUM_CNT-1:0] eff_load;
  logic [NUM_CNT-1:0] evt;
  logic wd_expire;

  // counter zero takes its settings from the watchdog state while in watchdog mode
  always_comb begin
    eff_run = run_bit_in;
    eff_ar = auto_reload_flag_in;
    eff_ptv = prescale_exponent_in;
    eff_reload = reload_value_in;
    eff_load = reload_write_in;
    if (s_r.wd_mode) begin
      eff_run[0] = 1'b1;
      eff_ar[0] = 1'b1;
      eff_ptv[0] = s_r.wd_ptv;
      eff_reload[0] = s_r.wd_reload;
      eff_load[0] = s_r.wd_load;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
      mtw_counter u_cnt (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .run_bit_in(eff_run[gi]),
        .auto_reload_flag_in(eff_ar[gi]),
        .prescale_exponent_in(eff_ptv[gi]),
        .reload_value_in(eff_reload[gi]),
        .load_in(eff_load[gi]),
        .count_out(count_readback_out[gi]),
        .zero_evt_out(evt[gi])
      );
    end
  endgenerate

  assign wd_expire = s_r.wd_mode && evt[0];

  always_comb begin
    s_nxt = s_r;
    s_nxt.wd_load = 1'b0;
    s_nxt.rst_pulse = wd_expire;
    if (reset_cause_clear_in) begin
      s_nxt.cause = 1'b0;
    end
    if (wd_expire) begin
      s_nxt.cause = 1'b1;
    end
    if (wd_expire) begin
      // the subsystem reset puts the watchdog back to its power-up setting
      s_nxt.key = KEY_IDLE;
      s_nxt.wd_reload = WD_RELOAD_RST;
      s_nxt.wd_ptv = WD_PTV_RST;
      s_nxt.last_load = WD_RELOAD_RST;
      s_nxt.wd_load = 1'b1;
    end else begin
      if (s_r.wd_mode && reload_write_in[0] && reload_value_in[0] != s_r.last_load) begin
        s_nxt.wd_reload = reload_value_in[0];
        s_nxt.last_load = reload_value_in[0];
        s_nxt.wd_load = 1'b1;
      end
      if (counter_zero_control_write_in) begin
        if (watchdog_bit_in) begin
          s_nxt.wd_mode = 1'b1;
          s_nxt.key = KEY_IDLE;
          s_nxt.wd_reload = WD_RELOAD_RST;
          s_nxt.last_load = WD_RELOAD_RST;
          s_nxt.wd_load = 1'b1;
        end else if (s_r.wd_mode) begin
          s_nxt.wd_ptv = prescale_exponent_in[0];
          case (s_r.key)
            KEY_IDLE: begin
              if (disable_key_field_in == KEY_FIRST) begin
                s_nxt.key = KEY_ARMED;
              end
            end
            KEY_ARMED: begin
              if (disable_key_field_in == KEY_SECOND) begin
                s_nxt.wd_mode = 1'b0;
                s_nxt.key = KEY_IDLE;
              end else if (disable_key_field_in == KEY_FIRST) begin
                s_nxt.key = KEY_ARMED;
              end else begin
                s_nxt.key = KEY_IDLE;
              end
            end
            default: begin
              s_nxt.key = KEY_IDLE;
            end
          endcase
        end
      end
    end
    s_nxt.pin = shared_io_timer_sel_in ? !evt[SHARED_CNT] : gpio_data_in;
    s_nxt.pin_oe = shared_io_timer_sel_in ? 1'b1 : gpio_oe_in;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r.wd_mode <= 1'b1;
      s_r.key <= KEY_IDLE;
      s_r.wd_reload <= WD_RELOAD_RST;
      s_r.wd_ptv <= WD_PTV_RST;
      s_r.last_load <= WD_RELOAD_RST;
      s_r.wd_load <= 1'b0;
      s_r.cause <= 1'b0;
      s_r.rst_pulse <= 1'b0;
      s_r.pin <= 1'b1;
      s_r.pin_oe <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign irq_out = evt;
  assign subsys_reset_out = s_r.rst_pulse;
  assign watchdog_mode_out = s_r.wd_mode;
  assign watchdog_reset_cause_out = s_r.cause;
  assign shared_io_pin_out = s_r.pin;
  assign shared_io_pin_oe_out = s_r.pin_oe;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence first_key_write;
    counter_zero_control_write_in && !watchdog_bit_in && disable_key_field_in == KEY_FIRST && watchdog_mode_out;
  endsequence
  sequence second_key_write;
    counter_zero_control_write_in && !watchdog_bit_in && disable_key_field_in == KEY_SECOND;
  endsequence
  sequence other_key_write;
    counter_zero_control_write_in && !watchdog_bit_in && disable_key_field_in != KEY_SECOND
      && disable_key_field_in != KEY_FIRST;
  endsequence
  // key steps are judged against the registered key state, so any spacing of writes is covered
  sequence armed_now;
    s_r.key == KEY_ARMED && !wd_expire;
  endsequence
  sequence idle_now;
    s_r.key == KEY_IDLE && !wd_expire;
  endsequence
  sequence new_wd_reload;
    watchdog_mode_out && reload_write_in[0] && reload_value_in[0] != s_r.last_load
      && !counter_zero_control_write_in && !wd_expire;
  endsequence

  a_key_disable: assert property (armed_now ##0 second_key_write |=> !watchdog_mode_out)
    else $error("key pair did not leave watchdog mode");
  a_key_disarm: assert property (armed_now ##0 other_key_write |=> watchdog_mode_out && s_r.key == KEY_IDLE)
    else $error("stray key did not disarm unlock");
  a_key_rearm: assert property (armed_now ##0 first_key_write |=> watchdog_mode_out && s_r.key == KEY_ARMED)
    else $error("repeated first key lost armed state");
  a_first_key_arms: assert property (idle_now ##0 first_key_write |=> s_r.key == KEY_ARMED)
    else $error("first key did not arm unlock");
  a_cause_sticky: assert property (watchdog_reset_cause_out && !reset_cause_clear_in |=> watchdog_reset_cause_out)
    else $error("reset cause dropped without clear");
  a_gp_no_reset: assert property (!watchdog_mode_out |=> !subsys_reset_out)
    else $error("subsystem reset outside watchdog mode");
  a_pin_oe_timer: assert property (shared_io_timer_sel_in |=> shared_io_pin_oe_out)
    else $error("shared pin not driven in timer function");
  a_wd_reload_load: assert property (new_wd_reload
      |=> s_r.wd_load ##1 count_readback_out[0] == $past(reload_value_in[0], 2))
    else $error("new watchdog reload not taken");
  a_wd_reenable: assert property (counter_zero_control_write_in && watchdog_bit_in && !wd_expire
      |=> watchdog_mode_out ##1 count_readback_out[0] == WD_RELOAD_RST)
    else $error("watchdog re-enable did not force full reload");
  a_wd_expiry_reset: assert property (evt[0] && watchdog_mode_out
      |=> subsys_reset_out && watchdog_reset_cause_out)
    else $error("watchdog expiry gave no reset");
  a_reset_cause: assert property ($rose(watchdog_reset_cause_out) |-> $past(wd_expire))
    else $error("reset cause set without expiry");
  a_same_value: assert property (watchdog_mode_out && reload_write_in[0] && reload_value_in[0] == s_r.last_load
      && !counter_zero_control_write_in && !wd_expire |=> !s_r.wd_load)
    else $error("identical watchdog reload restarted count");
  a_pin_pulse: assert property (shared_io_timer_sel_in && evt[SHARED_CNT]
      |=> !shared_io_pin_out && shared_io_pin_oe_out)
    else $error("shared pin missed low pulse");
  a_pin_idle_high: assert property (shared_io_timer_sel_in && !evt[SHARED_CNT] |=> shared_io_pin_out)
    else $error("shared pin low without event");
endmodule : mtw_timers

// [mtw_timers_tb.sv]
// self-checking bench for the three-counter timer block with watchdog
// assumes mtw_pkg is compiled first and design assertions live in the design files
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin bad_count++; \
  $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module mtw_timers_tb;
  import mtw_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [NUM_CNT-1:0] run_bit_in = '0;
  logic [NUM_CNT-1:0] auto_reload_flag_in = '0;
  logic [NUM_CNT-1:0][PTV_W-1:0] prescale_exponent_in = '0;
  logic [NUM_CNT-1:0][CNT_W-1:0] reload_value_in = '0;
  logic [NUM_CNT-1:0] reload_write_in = '0;
  logic counter_zero_control_write_in = 1'b0;
  logic [KEY_W-1:0] disable_key_field_in = 8'h00;
  logic watchdog_bit_in = 1'b0;
  logic reset_cause_clear_in = 1'b0;
  logic shared_io_timer_sel_in = 1'b1;
  logic gpio_data_in = 1'b1;
  logic gpio_oe_in = 1'b0;
  logic [NUM_CNT-1:0][CNT_W-1:0] count_readback_out;
  logic [NUM_CNT-1:0] irq_out;
  logic subsys_reset_out, watchdog_mode_out, watchdog_reset_cause_out;
  logic shared_io_pin_out, shared_io_pin_oe_out;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int t1, t2;
  logic [CNT_W-1:0] snap;

  mtw_timers i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .run_bit_in(run_bit_in),
    .auto_reload_flag_in(auto_reload_flag_in), .prescale_exponent_in(prescale_exponent_in),
    .reload_value_in(reload_value_in), .reload_write_in(reload_write_in),
    .counter_zero_control_write_in(counter_zero_control_write_in),
    .disable_key_field_in(disable_key_field_in), .watchdog_bit_in(watchdog_bit_in),
    .reset_cause_clear_in(reset_cause_clear_in), .shared_io_timer_sel_in(shared_io_timer_sel_in),
    .gpio_data_in(gpio_data_in), .gpio_oe_in(gpio_oe_in), .count_readback_out(count_readback_out),
    .irq_out(irq_out), .subsys_reset_out(subsys_reset_out), .watchdog_mode_out(watchdog_mode_out),
    .watchdog_reset_cause_out(watchdog_reset_cause_out), .shared_io_pin_out(shared_io_pin_out),
    .shared_io_pin_oe_out(shared_io_pin_oe_out));

  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // hang guard, far above the planned run length
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cycles

  task automatic wait_irq(input int idx, input int lim, output int at);
    at = -1;
    for (int i = 0; i < lim && at < 0; i++) begin
      @(posedge clk_sys_in);
      #1;
      if (irq_out[idx] === 1'b1) at = cyc;
    end
    `CHK("irq seen", 1'b1, at >= 0)
  endtask : wait_irq

  task automatic wr_reload(input int idx, input logic [CNT_W-1:0] val);
    @(posedge clk_sys_in);
    reload_value_in[idx] <= val;
    reload_write_in[idx] <= 1'b1;
    @(posedge clk_sys_in);
    reload_write_in[idx] <= 1'b0;
  endtask : wr_reload

  task automatic wr_ctl(input logic [KEY_W-1:0] key, input logic wd);
    @(posedge clk_sys_in);
    disable_key_field_in <= key;
    watchdog_bit_in <= wd;
    counter_zero_control_write_in <= 1'b1;
    @(posedge clk_sys_in);
    counter_zero_control_write_in <= 1'b0;
  endtask : wr_ctl

  task automatic t_power_up;
    cycles(5);
    `CHK("wd mode", 1'b1, watchdog_mode_out)
    `CHK("wd count", WD_RELOAD_RST, count_readback_out[0])
    `CHK("cause", 1'b0, watchdog_reset_cause_out)
  endtask : t_power_up

  task automatic t_period_hold;
    @(posedge clk_sys_in);
    auto_reload_flag_in[1] <= 1'b1;
    wr_reload(1, 16'h0003);
    run_bit_in[1] <= 1'b1;
    wait_irq(1, 100, t1);
    wait_irq(1, 100, t2);
    `CHK("period", 8, t2 - t1)
    wait_irq(1, 100, t2);
    `CHK("reload period", 8, t2 - t1 - 8)
    cycles(3);
    @(posedge clk_sys_in);
    run_bit_in[1] <= 1'b0;
    cycles(2);
    snap = count_readback_out[1];
    cycles(12);
    `CHK("held count", snap, count_readback_out[1])
  endtask : t_period_hold

  task automatic t_oneshot_pin;
    @(posedge clk_sys_in);
    prescale_exponent_in[2] <= 3'h1;
    wr_reload(2, 16'h0002);
    run_bit_in[2] <= 1'b1;
    wait_irq(2, 100, t1);
    cycles(1);
    `CHK("pin low", 1'b0, shared_io_pin_out)
    `CHK("pin oe", 1'b1, shared_io_pin_oe_out)
    cycles(1);
    `CHK("pin high", 1'b1, shared_io_pin_out)
    for (int i = 0; i < 40; i++) begin
      cycles(1);
      `CHK("no refire", 1'b0, irq_out[2])
    end
    `CHK("zero hold", 16'h0000, count_readback_out[2])
    @(posedge clk_sys_in);
    shared_io_timer_sel_in <= 1'b0;
    gpio_data_in <= 1'b0;
    gpio_oe_in <= 1'b1;
    cycles(2);
    `CHK("gpio pin", 2'b01, {shared_io_pin_out, shared_io_pin_oe_out})
    @(posedge clk_sys_in);
    shared_io_timer_sel_in <= 1'b1;
    gpio_oe_in <= 1'b0;
  endtask : t_oneshot_pin

  task automatic t_watchdog;
    @(posedge clk_sys_in);
    prescale_exponent_in[0] <= 3'h0;
    wr_ctl(8'h00, 1'b0);
    wr_reload(0, 16'h0014);
    cycles(10);
    wr_reload(0, 16'h0014);
    cycles(4);
    `CHK("same value ignored", 1'b1, count_readback_out[0] < 16'h0012)
    wait_irq(0, 100, t1);
    cycles(1);
    `CHK("subsys reset", 1'b1, subsys_reset_out)
    `CHK("cause set", 1'b1, watchdog_reset_cause_out)
    @(posedge clk_sys_in);
    reset_cause_clear_in <= 1'b1;
    @(posedge clk_sys_in);
    reset_cause_clear_in <= 1'b0;
    cycles(2);
    `CHK("cause clear", 1'b0, watchdog_reset_cause_out)
  endtask : t_watchdog

  task automatic t_keys;
    @(posedge clk_sys_in);
    prescale_exponent_in[0] <= 3'h7;
    wr_ctl(KEY_FIRST, 1'b0);
    wr_ctl(8'h33, 1'b0);
    wr_ctl(KEY_SECOND, 1'b0);
    cycles(2);
    `CHK("disarmed", 1'b1, watchdog_mode_out)
    wr_ctl(KEY_FIRST, 1'b0);
    wr_ctl(KEY_FIRST, 1'b0);
    cycles(2);
    `CHK("still wd", 1'b1, watchdog_mode_out)
    wr_ctl(KEY_SECOND, 1'b0);
    cycles(2);
    `CHK("gp mode", 1'b0, watchdog_mode_out)
    wr_ctl(8'h00, 1'b1);
    cycles(4);
    `CHK("wd again", 1'b1, watchdog_mode_out)
    `CHK("forced max", WD_RELOAD_RST, count_readback_out[0])
  endtask : t_keys

  task automatic results;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_power_up();
    t_period_hold();
    t_oneshot_pin();
    t_watchdog();
    t_keys();
    results();
  end
endmodule : mtw_timers_tb
